// >>> rtl/mwsc_wait_ctrl.sv
// Operation
// - 32-bit peripheral frame: CPU write 0, read 2 waits; DMA refused; ready stretches.
// - Back-to-back CPU writes to 32-bit peripheral frame add one cycle.
// - 16-bit peripheral frame: write 0, read 2 waits, no stretch, DMA refused.
// - DMA peripheral frame: CPU write 0/read 2; DMA write 0/read 1.
// - Lower four RAM blocks: CPU zero waits, DMA refused.
// - Upper RAM blocks: CPU data 0, program 1 wait; DMA 0 waits.
// - External port waits from timing registers, stretched by external ready.
// - External pin waveforms never use fewer than one wait.
// - External writes finish with zero waits only with buffer enabled and free.
// - Simultaneous CPU and DMA external requests add one arbitration cycle.
// - OTP uses programmed waits, minimum one; DMA refused.
// - Flash paged/random waits at least one, random not below paged; DMA refused.
// - Flash password reads always take sixteen waits.
// - Boot ROM takes exactly one wait; DMA refused.
// - Each DMA word costs four cycles plus region waits.
module mwsc_wait_ctrl (
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 clk_en_in,
	input  wire logic                 cpu_req_in,
	input  wire logic                 cpu_wr_in,
	input  wire logic                 cpu_prog_in,
	input  wire mwsc_pkg::mwsc_region_t cpu_region_in,
	input  wire logic                 dma_req_in,
	input  wire logic                 dma_wr_in,
	input  wire mwsc_pkg::mwsc_region_t dma_region_in,
	input  wire logic                 periph_ready_in,
	input  wire logic                 external_ready_input_in,
	input  wire logic [4:0]           ext_rd_wait_in,
	input  wire logic [4:0]           ext_wr_wait_in,
	input  wire logic                 wbuf_enable_in,
	input  wire logic                 wbuf_full_in,
	input  wire logic [4:0]           otp_wait_in,
	input  wire logic [4:0]           flash_page_wait_in,
	input  wire logic [4:0]           flash_rand_wait_in,
	input  wire logic                 flash_random_in,
	output logic                      cpu_busy_out,
	output logic                      cpu_done_out,
	output logic                      cpu_refused_out,
	output logic                      dma_busy_out,
	output logic                      dma_done_out,
	output logic                      dma_refused_out
);
	typedef enum logic [1:0] {MWSC_IDLE, MWSC_WAIT, MWSC_STRETCH} mwsc_state_t;

	// Waits for one master's access; refused flagged separately
	function automatic logic [4:0] region_wait(input mwsc_pkg::mwsc_region_t rgn, input logic is_dma,
		input logic wr, input logic prog, input logic [4:0] ext_w, input logic [4:0] otp_w,
		input logic [4:0] fl_w);
		logic [4:0] w;
		w = mwsc_pkg::WAIT_ZERO;
		case (rgn)
			mwsc_pkg::MWSC_RGN_PF0:       w = (wr || is_dma) ? mwsc_pkg::WAIT_ZERO : mwsc_pkg::WAIT_ONE;
			mwsc_pkg::MWSC_RGN_PF1:       w = wr ? mwsc_pkg::WAIT_ZERO : mwsc_pkg::WAIT_TWO;
			mwsc_pkg::MWSC_RGN_PF2:       w = wr ? mwsc_pkg::WAIT_ZERO : mwsc_pkg::WAIT_TWO;
			mwsc_pkg::MWSC_RGN_PF3:       w = wr ? mwsc_pkg::WAIT_ZERO :
				(is_dma ? mwsc_pkg::WAIT_ONE : mwsc_pkg::WAIT_TWO);
			mwsc_pkg::MWSC_RGN_RAM_HIGH:  w = (prog && !is_dma) ? mwsc_pkg::WAIT_ONE : mwsc_pkg::WAIT_ZERO;
			mwsc_pkg::MWSC_RGN_EXT:       w = ext_w;
			mwsc_pkg::MWSC_RGN_OTP:       w = otp_w;
			mwsc_pkg::MWSC_RGN_FLASH:     w = fl_w;
			mwsc_pkg::MWSC_RGN_FLASH_PWD: w = mwsc_pkg::WAIT_PASSWORD;
			mwsc_pkg::MWSC_RGN_BOOT_ROM:  w = mwsc_pkg::WAIT_ONE;
			default:                      w = mwsc_pkg::WAIT_ZERO;
		endcase
		return w;
	endfunction : region_wait

	function automatic logic dma_refused(input mwsc_pkg::mwsc_region_t rgn, input logic wr);
		logic r;
		r = 1'b0;
		case (rgn)
			mwsc_pkg::MWSC_RGN_PF0:       r = wr;
			mwsc_pkg::MWSC_RGN_PF1,
			mwsc_pkg::MWSC_RGN_PF2,
			mwsc_pkg::MWSC_RGN_RAM_LOW,
			mwsc_pkg::MWSC_RGN_OTP,
			mwsc_pkg::MWSC_RGN_FLASH,
			mwsc_pkg::MWSC_RGN_FLASH_PWD,
			mwsc_pkg::MWSC_RGN_BOOT_ROM,
			mwsc_pkg::MWSC_RGN_SMALL_RAM,
			mwsc_pkg::MWSC_RGN_NONE:      r = 1'b1;
			default:                      r = 1'b0;
		endcase
		return r;
	endfunction : dma_refused

	function automatic logic [4:0] max5(input logic [4:0] a, input logic [4:0] b);
		return (a > b) ? a : b;
	endfunction : max5

	// Pin inputs synchronised
	logic periph_rdy_s1_ff, periph_rdy_ff, xrdy_s1_ff, xrdy_ff;

	// Programmed wait values clamped to their minimums
	wire logic [4:0] ext_rd_w    = max5(ext_rd_wait_in, mwsc_pkg::WAIT_MIN_EXT);
	wire logic [4:0] ext_wr_pin  = max5(ext_wr_wait_in, mwsc_pkg::WAIT_MIN_EXT);
	wire logic       wbuf_free   = wbuf_enable_in && !wbuf_full_in;
	wire logic [4:0] otp_w       = max5(otp_wait_in, mwsc_pkg::WAIT_MIN_FLASH);
	wire logic [4:0] page_w      = max5(flash_page_wait_in, mwsc_pkg::WAIT_MIN_FLASH);
	wire logic [4:0] rand_w      = max5(flash_rand_wait_in, page_w);
	wire logic [4:0] fl_w        = flash_random_in ? rand_w : page_w;

	// Write buffer absorbs a write only when free
	function automatic logic [4:0] ext_wait(input logic wr, input logic [4:0] rd_w, input logic [4:0] wr_w,
		input logic buf_free);
		return wr ? (buf_free ? mwsc_pkg::WAIT_ZERO : wr_w) : rd_w;
	endfunction : ext_wait

	wire logic [4:0] cpu_ext_w = ext_wait(cpu_wr_in, ext_rd_w, ext_wr_pin, wbuf_free);
	wire logic [4:0] dma_ext_w = ext_wait(dma_wr_in, ext_rd_w, ext_wr_pin, wbuf_free);
	wire logic       ext_clash = cpu_req_in && dma_req_in && cpu_region_in == mwsc_pkg::MWSC_RGN_EXT
		&& dma_region_in == mwsc_pkg::MWSC_RGN_EXT;

	mwsc_state_t cpu_st_ff, dma_st_ff;
	logic [4:0]  cpu_cnt_ff, dma_cnt_ff;
	logic        cpu_stretch_ff, dma_stretch_ff;
	logic        pf1_wr_last_ff;

	wire logic       cpu_start    = clk_en_in && cpu_st_ff == MWSC_IDLE && cpu_req_in;
	wire logic       dma_start    = clk_en_in && dma_st_ff == MWSC_IDLE && dma_req_in;
	wire logic       dma_refuse   = dma_refused(dma_region_in, dma_wr_in);
	wire logic       cpu_pf1_wr   = cpu_region_in == mwsc_pkg::MWSC_RGN_PF1 && cpu_wr_in;
	wire logic [4:0] cpu_base_w   = region_wait(cpu_region_in, 1'b0, cpu_wr_in, cpu_prog_in, cpu_ext_w,
		otp_w, fl_w);
	// CPU loses arbitration on a clash, so the extra cycle lands on the CPU
	wire logic [4:0] cpu_hit      = (cpu_pf1_wr && pf1_wr_last_ff) ? mwsc_pkg::PF1_WR_HIT : mwsc_pkg::WAIT_ZERO;
	wire logic [4:0] cpu_arb      = ext_clash ? mwsc_pkg::ARB_DELAY : mwsc_pkg::WAIT_ZERO;
	wire logic [4:0] nxt_cpu_cnt  = 5'(cpu_base_w + cpu_hit + cpu_arb);
	wire logic [4:0] dma_region_w = region_wait(dma_region_in, 1'b1, dma_wr_in, 1'b0, dma_ext_w, otp_w, fl_w);
	// Base cost counted as busy cycles beyond the issuing one
	wire logic [4:0] nxt_dma_cnt  = 5'(dma_region_w + mwsc_pkg::DMA_BASE_COST - mwsc_pkg::WAIT_ONE);
	wire logic       cpu_rgn_rdy  = (cpu_region_in == mwsc_pkg::MWSC_RGN_PF1) ||
		(cpu_region_in == mwsc_pkg::MWSC_RGN_EXT && !(cpu_wr_in && wbuf_free));
	wire logic       dma_rgn_rdy  = dma_region_in == mwsc_pkg::MWSC_RGN_EXT && !(dma_wr_in && wbuf_free);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			periph_rdy_s1_ff <= 1'b1;
			periph_rdy_ff    <= 1'b1;
			xrdy_s1_ff       <= 1'b1;
			xrdy_ff          <= 1'b1;
		end else if (clk_en_in) begin
			periph_rdy_s1_ff <= periph_ready_in;
			periph_rdy_ff    <= periph_rdy_s1_ff;
			xrdy_s1_ff       <= external_ready_input_in;
			xrdy_ff          <= xrdy_s1_ff;
		end
	end

	// CPU access sequencer; request and region held stable until done
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cpu_st_ff       <= MWSC_IDLE;
			cpu_cnt_ff      <= mwsc_pkg::WAIT_ZERO;
			cpu_stretch_ff  <= 1'b0;
			cpu_busy_out    <= 1'b0;
			cpu_done_out    <= 1'b0;
			cpu_refused_out <= 1'b0;
			pf1_wr_last_ff  <= 1'b0;
		end else if (clk_en_in) begin
			cpu_done_out    <= 1'b0;
			cpu_refused_out <= 1'b0;
			case (cpu_st_ff)
				MWSC_IDLE: begin
					if (cpu_req_in) begin
						cpu_cnt_ff     <= nxt_cpu_cnt;
						cpu_stretch_ff <= cpu_rgn_rdy;
						cpu_busy_out   <= 1'b1;
						pf1_wr_last_ff <= cpu_pf1_wr;
						cpu_st_ff      <= MWSC_WAIT;
					end else begin
						pf1_wr_last_ff <= 1'b0;
					end
				end
				MWSC_WAIT: begin
					if (cpu_cnt_ff != mwsc_pkg::WAIT_ZERO) begin
						cpu_cnt_ff <= 5'(cpu_cnt_ff - mwsc_pkg::WAIT_ONE);
					end else begin
						cpu_st_ff <= MWSC_STRETCH;
					end
				end
				MWSC_STRETCH: begin
					if (!cpu_stretch_ff || (cpu_region_in == mwsc_pkg::MWSC_RGN_PF1 ? periph_rdy_ff : xrdy_ff)) begin
						cpu_busy_out <= 1'b0;
						cpu_done_out <= 1'b1;
						cpu_st_ff    <= MWSC_IDLE;
					end
				end
				default: cpu_st_ff <= MWSC_IDLE;
			endcase
		end
	end

	// DMA access sequencer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dma_st_ff       <= MWSC_IDLE;
			dma_cnt_ff      <= mwsc_pkg::WAIT_ZERO;
			dma_stretch_ff  <= 1'b0;
			dma_busy_out    <= 1'b0;
			dma_done_out    <= 1'b0;
			dma_refused_out <= 1'b0;
		end else if (clk_en_in) begin
			dma_done_out    <= 1'b0;
			dma_refused_out <= 1'b0;
			case (dma_st_ff)
				MWSC_IDLE: begin
					if (dma_req_in && dma_refuse) begin
						dma_refused_out <= 1'b1;
					end else if (dma_req_in) begin
						dma_cnt_ff     <= nxt_dma_cnt;
						dma_stretch_ff <= dma_rgn_rdy;
						dma_busy_out   <= 1'b1;
						dma_st_ff      <= MWSC_WAIT;
					end
				end
				MWSC_WAIT: begin
					if (dma_cnt_ff != mwsc_pkg::WAIT_ZERO) begin
						dma_cnt_ff <= 5'(dma_cnt_ff - mwsc_pkg::WAIT_ONE);
					end else begin
						dma_st_ff <= MWSC_STRETCH;
					end
				end
				MWSC_STRETCH: begin
					if (!dma_stretch_ff || xrdy_ff) begin
						dma_busy_out <= 1'b0;
						dma_done_out <= 1'b1;
						dma_st_ff    <= MWSC_IDLE;
					end
				end
				default: dma_st_ff <= MWSC_IDLE;
			endcase
		end
	end

	default clocking mwsc_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence cpu_pwd_start;
		cpu_start && cpu_region_in == mwsc_pkg::MWSC_RGN_FLASH_PWD && !ext_clash;
	endsequence

	sequence cpu_pf2_rd_start;
		cpu_start && cpu_region_in == mwsc_pkg::MWSC_RGN_PF2 && !cpu_wr_in;
	endsequence

	sequence dma_pf3_rd_start;
		dma_start && dma_region_in == mwsc_pkg::MWSC_RGN_PF3 && !dma_wr_in;
	endsequence

	sequence cpu_pf1_held;
		cpu_st_ff == MWSC_STRETCH && cpu_stretch_ff && !periph_rdy_ff
		&& cpu_region_in == mwsc_pkg::MWSC_RGN_PF1;
	endsequence

	sequence cpu_ext_held;
		cpu_st_ff == MWSC_STRETCH && cpu_stretch_ff && !xrdy_ff
		&& cpu_region_in == mwsc_pkg::MWSC_RGN_EXT;
	endsequence

	chk_pwd_sixteen_waits: assert property (cpu_pwd_start ##1 clk_en_in [*8]
		##1 clk_en_in [*8] ##1 clk_en_in [*2] |=> cpu_done_out) else $error("password access not 16 waits");

	chk_pf2_read_two: assert property (cpu_pf2_rd_start ##1 clk_en_in [*4] |=> cpu_done_out)
		else $error("16-bit frame read timing wrong");

	chk_pf1_write_hit: assert property (cpu_start && cpu_pf1_wr && pf1_wr_last_ff
		|-> nxt_cpu_cnt == 5'h01) else $error("back-to-back write hit missing");

	chk_dma_refused_pf1: assert property (dma_start && dma_region_in == mwsc_pkg::MWSC_RGN_PF1
		|=> dma_refused_out && !dma_busy_out) else $error("dma not refused");

	chk_ext_min_wait: assert property (cpu_start && cpu_region_in == mwsc_pkg::MWSC_RGN_EXT && !cpu_wr_in
		|-> nxt_cpu_cnt >= 5'h01) else $error("external read below one wait");

	chk_ext_clash_delay: assert property (cpu_start && ext_clash && cpu_wr_in && wbuf_free
		|-> nxt_cpu_cnt == 5'h01) else $error("arbitration cycle missing");

	chk_dma_base_cost: assert property (dma_start && !dma_refuse |-> nxt_dma_cnt >= 5'h03)
		else $error("dma base cost short");

	chk_flash_rand_ge: assert property (rand_w >= page_w && page_w >= 5'h01)
		else $error("flash wait ordering broken");

	chk_boot_one_wait: assert property (cpu_start && cpu_region_in == mwsc_pkg::MWSC_RGN_BOOT_ROM
		|-> nxt_cpu_cnt == 5'h01) else $error("boot rom not one wait");

	chk_dma_pf3_read: assert property (dma_pf3_rd_start ##1 clk_en_in [*6] |=> dma_done_out)
		else $error("dma peripheral read timing wrong");

	chk_pf1_ready_hold: assert property (cpu_pf1_held |=> !cpu_done_out)
		else $error("peripheral ready ignored");

	chk_ext_ready_hold: assert property (cpu_ext_held |=> !cpu_done_out)
		else $error("external ready ignored");

	chk_dma_refuse_mem: assert property (dma_start && (dma_region_in == mwsc_pkg::MWSC_RGN_OTP
		|| dma_region_in == mwsc_pkg::MWSC_RGN_FLASH || dma_region_in == mwsc_pkg::MWSC_RGN_BOOT_ROM)
		|=> dma_refused_out && !dma_busy_out) else $error("dma reached a memory it may not use");

	chk_wbuf_dma_write: assert property (dma_start && dma_region_in == mwsc_pkg::MWSC_RGN_EXT && dma_wr_in
		&& wbuf_free |-> nxt_dma_cnt == 5'h03) else $error("buffered write not zero waits");

	chk_ram_high_prog: assert property (cpu_start && cpu_region_in == mwsc_pkg::MWSC_RGN_RAM_HIGH
		&& cpu_prog_in |-> nxt_cpu_cnt == 5'h01) else $error("program access not one wait");

	chk_small_ram_zero: assert property (cpu_start && (cpu_region_in == mwsc_pkg::MWSC_RGN_SMALL_RAM
		|| cpu_region_in == mwsc_pkg::MWSC_RGN_RAM_LOW) |-> nxt_cpu_cnt == 5'h00)
		else $error("local ram not zero waits");
endmodule : mwsc_wait_ctrl

// >>> rtl/mwsc_pkg.sv
package mwsc_pkg;
	// Region codes delivered by the external address decoder
	typedef enum logic [3:0] {
		MWSC_RGN_NONE,
		MWSC_RGN_SMALL_RAM,
		MWSC_RGN_PF0,
		MWSC_RGN_PF1,
		MWSC_RGN_PF2,
		MWSC_RGN_PF3,
		MWSC_RGN_RAM_LOW,
		MWSC_RGN_RAM_HIGH,
		MWSC_RGN_EXT,
		MWSC_RGN_OTP,
		MWSC_RGN_FLASH,
		MWSC_RGN_FLASH_PWD,
		MWSC_RGN_BOOT_ROM
	} mwsc_region_t;

	localparam int          WAIT_W         = 5;
	localparam logic [4:0]  WAIT_ZERO      = 5'h00;
	localparam logic [4:0]  WAIT_ONE       = 5'h01;
	localparam logic [4:0]  WAIT_TWO       = 5'h02;
	localparam logic [4:0]  WAIT_PASSWORD  = 5'h10;
	localparam logic [4:0]  WAIT_MIN_EXT   = 5'h01;
	localparam logic [4:0]  WAIT_MIN_FLASH = 5'h01;
	localparam logic [4:0]  DMA_BASE_COST  = 5'h04;
	localparam logic [4:0]  PF1_WR_HIT     = 5'h01;
	localparam logic [4:0]  ARB_DELAY      = 5'h01;
endpackage : mwsc_pkg

// >>> sim/mwsc_master_model.sv
module mwsc_master_model (
	input  wire logic              clk_in,
	input  wire logic              done_in,
	input  wire logic              refused_in,
	output logic                   req_out,
	output logic                   wr_out,
	output logic                   prog_out,
	output mwsc_pkg::mwsc_region_t region_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_out = 1'b0;
		wr_out = 1'b0;
		prog_out = 1'b0;
		region_out = mwsc_pkg::MWSC_RGN_NONE;
	end
	// Holds the request until answered; n accesses back to back
	task automatic access(input mwsc_pkg::mwsc_region_t rg, input logic wr, input logic prog, input int n);
		@(negedge clk_in);
		req_out = 1'b1;
		wr_out = wr;
		prog_out = prog;
		region_out = rg;
		repeat (n) begin
			@(negedge clk_in);
			while (!(done_in || refused_in)) @(negedge clk_in);
		end
		// Released lines show the inverse, not the last value
		req_out = 1'b0;
		wr_out = ~wr;
		prog_out = ~prog;
		region_out = mwsc_pkg::mwsc_region_t'(~rg);
	endtask : access
endmodule : mwsc_master_model

// >>> sim/mwsc_wait_ctrl_tb.sv
module mwsc_wait_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, clk_en, en_rand, en_q, p_rdy, x_rdy, wb_en, wb_full, fl_rnd;
	logic [4:0] x_rd, x_wr, otp_w, fl_pg, fl_rw;
	logic c_req, c_wr, c_prog, c_busy, c_done, c_ref, d_req, d_wr, d_busy, d_done, d_ref;
	mwsc_pkg::mwsc_region_t c_rg, d_rg;
	int cq[$], dq[$], cnt_c, cnt_d, cyc, bad_count, checks_done;
	mwsc_wait_ctrl mwsc_wait_ctrl_i (.clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en), .cpu_req_in(c_req),
		.cpu_wr_in(c_wr), .cpu_prog_in(c_prog), .cpu_region_in(c_rg), .dma_req_in(d_req), .dma_wr_in(d_wr),
		.dma_region_in(d_rg), .periph_ready_in(p_rdy), .external_ready_input_in(x_rdy), .ext_rd_wait_in(x_rd),
		.ext_wr_wait_in(x_wr), .wbuf_enable_in(wb_en), .wbuf_full_in(wb_full), .otp_wait_in(otp_w),
		.flash_page_wait_in(fl_pg), .flash_rand_wait_in(fl_rw), .flash_random_in(fl_rnd), .cpu_busy_out(c_busy),
		.cpu_done_out(c_done), .cpu_refused_out(c_ref), .dma_busy_out(d_busy), .dma_done_out(d_done),
		.dma_refused_out(d_ref));
	mwsc_master_model mwsc_master_model_cpu_i (.clk_in(clk), .done_in(c_done), .refused_in(1'b0),
		.req_out(c_req), .wr_out(c_wr), .prog_out(c_prog), .region_out(c_rg));
	mwsc_master_model mwsc_master_model_dma_i (.clk_in(clk), .done_in(d_done), .refused_in(d_ref),
		.req_out(d_req), .wr_out(d_wr), .prog_out(), .region_out(d_rg));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Negative expectation means at least that many cycles; zero means refused
	task automatic chk_lat(input int got, input int exp);
		checks_done++;
		if (exp < 0 ? got < -exp : got != exp) begin
			bad_count++;
			$display("[FAIL] %0t latency %0d expected %0d", $time, got, exp);
		end
	endtask : chk_lat
	task automatic chk_flag(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_flag
	task automatic conclude();
		$display("Checks %0d, errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic run(input logic dma, input mwsc_pkg::mwsc_region_t rg, input logic wr, input logic pg, input int e);
		if (dma) begin
			dq.push_back(e);
			mwsc_master_model_dma_i.access(rg, wr, pg, 1);
		end else begin
			cq.push_back(e);
			mwsc_master_model_cpu_i.access(rg, wr, pg, 1);
		end
	endtask : run
	// Ready held low for twelve cycles must lengthen the read
	task automatic stretch(input logic ext, input mwsc_pkg::mwsc_region_t rg);
		p_rdy = ext;
		x_rdy = !ext;
		fork
			run(1'b0, rg, 1'b0, 1'b0, -12);
			begin
				repeat (12) @(negedge clk);
				p_rdy = 1'b1;
				x_rdy = 1'b1;
			end
		join
	endtask : stretch
	// Enabled edges only; a frozen done is seen once
	always @(posedge clk) begin
		en_q <= clk_en;
		if (c_busy && clk_en) cnt_c++;
		if (d_busy && clk_en) cnt_d++;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	always @(negedge clk) begin
		clk_en <= en_rand ? 1'($urandom) : 1'b1;
		if (rst_n === 1'b1) chk_flag(c_ref, 1'b0);
		if (en_q === 1'b1 && c_done === 1'b1) begin
			chk_lat(cnt_c, cq.size() ? cq.pop_front() : 99);
			cnt_c = 0;
		end
		if (en_q === 1'b1 && (d_done === 1'b1 || d_ref === 1'b1)) begin
			chk_lat(d_ref === 1'b1 ? 0 : cnt_d, dq.size() ? dq.pop_front() : 99);
			cnt_d = 0;
		end
	end
	initial begin
		{rst_n, en_rand, wb_en, wb_full, fl_rnd} = '0;
		{p_rdy, x_rdy} = '1;
		{x_rd, x_wr, otp_w, fl_pg, fl_rw} = {5'h03, 5'h02, 5'h02, 5'h02, 5'h03};
		void'($urandom(4));
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		run(0, mwsc_pkg::MWSC_RGN_PF1, 1, 0, 2);
		run(0, mwsc_pkg::MWSC_RGN_PF1, 0, 0, 4);
		run(1, mwsc_pkg::MWSC_RGN_PF1, 0, 0, 0);
		stretch(0, mwsc_pkg::MWSC_RGN_PF1);
		cq.push_back(2);
		cq.push_back(3);
		mwsc_master_model_cpu_i.access(mwsc_pkg::MWSC_RGN_PF1, 1, 0, 2);
		run(0, mwsc_pkg::MWSC_RGN_PF2, 1, 0, 2);
		p_rdy = 1'b0;
		run(0, mwsc_pkg::MWSC_RGN_PF2, 0, 0, 4);
		p_rdy = 1'b1;
		run(1, mwsc_pkg::MWSC_RGN_PF2, 1, 0, 0);
		en_rand = 1'b1;
		run(0, mwsc_pkg::MWSC_RGN_PF2, 0, 0, 4);
		en_rand = 1'b0;
		run(0, mwsc_pkg::MWSC_RGN_PF3, 1, 0, 2);
		run(0, mwsc_pkg::MWSC_RGN_PF3, 0, 0, 4);
		run(1, mwsc_pkg::MWSC_RGN_PF3, 1, 0, 5);
		run(1, mwsc_pkg::MWSC_RGN_PF3, 0, 0, 6);
		run(0, mwsc_pkg::MWSC_RGN_RAM_LOW, 1, 0, 2);
		run(1, mwsc_pkg::MWSC_RGN_RAM_LOW, 0, 0, 0);
		run(0, mwsc_pkg::MWSC_RGN_RAM_HIGH, 0, 0, 2);
		run(0, mwsc_pkg::MWSC_RGN_RAM_HIGH, 1, 1, 3);
		run(1, mwsc_pkg::MWSC_RGN_RAM_HIGH, 1, 0, 5);
		repeat (4) begin
			x_rd = 5'($urandom_range(8, 0));
			run(0, mwsc_pkg::MWSC_RGN_EXT, 0, 0, (x_rd == 5'h00 ? 1 : int'(x_rd)) + 2);
		end
		x_wr = 5'h00;
		run(0, mwsc_pkg::MWSC_RGN_EXT, 1, 0, 3);
		wb_en = 1'b1;
		run(1, mwsc_pkg::MWSC_RGN_EXT, 1, 0, 5);
		wb_full = 1'b1;
		run(0, mwsc_pkg::MWSC_RGN_EXT, 1, 0, 3);
		{wb_en, wb_full} = 2'h0;
		stretch(1, mwsc_pkg::MWSC_RGN_EXT);
		x_rd = 5'h02;
		fork
			run(0, mwsc_pkg::MWSC_RGN_EXT, 0, 0, 5);
			run(1, mwsc_pkg::MWSC_RGN_EXT, 0, 0, 7);
		join
		wb_en = 1'b1;
		fork
			run(0, mwsc_pkg::MWSC_RGN_EXT, 1, 0, 3);
			run(1, mwsc_pkg::MWSC_RGN_EXT, 1, 0, 5);
		join
		wb_en = 1'b0;
		otp_w = 5'h00;
		run(0, mwsc_pkg::MWSC_RGN_OTP, 0, 0, 3);
		otp_w = 5'h04;
		run(0, mwsc_pkg::MWSC_RGN_OTP, 0, 0, 6);
		run(1, mwsc_pkg::MWSC_RGN_OTP, 0, 0, 0);
		{fl_pg, fl_rw} = 10'h000;
		run(0, mwsc_pkg::MWSC_RGN_FLASH, 0, 0, 3);
		{fl_pg, fl_rw, fl_rnd} = {5'h03, 5'h01, 1'b1};
		run(0, mwsc_pkg::MWSC_RGN_FLASH, 0, 0, 5);
		run(1, mwsc_pkg::MWSC_RGN_FLASH, 0, 0, 0);
		run(0, mwsc_pkg::MWSC_RGN_FLASH_PWD, 0, 0, 18);
		run(1, mwsc_pkg::MWSC_RGN_FLASH_PWD, 0, 0, 0);
		run(0, mwsc_pkg::MWSC_RGN_BOOT_ROM, 0, 0, 3);
		run(1, mwsc_pkg::MWSC_RGN_BOOT_ROM, 0, 0, 0);
		run(0, mwsc_pkg::MWSC_RGN_PF0, 1, 0, 2);
		run(0, mwsc_pkg::MWSC_RGN_PF0, 0, 0, 3);
		run(1, mwsc_pkg::MWSC_RGN_PF0, 0, 0, 5);
		run(1, mwsc_pkg::MWSC_RGN_PF0, 1, 0, 0);
		run(0, mwsc_pkg::MWSC_RGN_SMALL_RAM, 0, 0, 2);
		run(1, mwsc_pkg::MWSC_RGN_NONE, 0, 0, 0);
		repeat (5) @(negedge clk);
		conclude();
	end
endmodule : mwsc_wait_ctrl_tb
